// ==== hw/ofr_top.v ====
`timescale 1ns/100ps
`include "ofr_regs.vh"

module ofr_top
#(
    parameter [7:0] PAGE_ID = 8'h00,
    parameter       TW      = 16
)
(
    // clock and reset
    input  wire          mclk_i,
    input  wire          sys_rst_i,
    // decoded command strobes from the serial engine
    input  wire          cmd_wr_i,
    input  wire          cmd_rd_i,
    input  wire [7:0]    cmd_code_i,
    input  wire [7:0]    cmd_page_i,
    input  wire [7:0]    cmd_data_i,
    input  wire          clear_faults_i,
    output reg  [7:0]    cmd_rd_data_o,
    // settings kept elsewhere
    input  wire [TW-1:0] restart_interval_setting_i,
    input  wire [TW-1:0] ton_max_limit_i,
    input  wire          uv_alert_mask_i,
    input  wire          ton_alert_mask_i,
    // channel control and sequencer
    input  wire          channel_run_pin_i,
    input  wire          operation_on_i,
    input  wire          ton_delay_done_i,
    input  wire          ton_rise_done_i,
    input  wire          rise_active_i,
    input  wire          fall_active_i,
    input  wire          oc_present_i,
    input  wire          other_latch_fault_i,
    // analog comparator, low while output under threshold
    input  wire          uv_above_i,
    // status flags
    output reg           status_word_vout_o,
    output reg           status_vout_uv_o,
    output reg           status_vout_ton_o,
    output reg           status_byte_nota_o,
    output reg           status_cml_o,
    // output drive
    output wire          chan_enable_o,
    // alert open-drain pin
    input  wire          alert_in_i,
    output wire          alert_out_o,
    output wire          alert_oe_o
);

// ****************************************************
// state codes
// ****************************************************
localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_RUN   = 3'h1;
localparam [2:0] ST_DELAY = 3'h2;
localparam [2:0] ST_LATCH = 3'h3;
localparam [2:0] ST_RETRY = 3'h4;
localparam [31:0] UNIT_CYC  = `OFR_UNIT_CYCLES;
localparam [7:0]  UNIT_LAST = UNIT_CYC[7:0] - 8'h01;

// ****************************************************
// helpers
// ****************************************************
// a command applies to this page or to all pages
function page_hit;
    input [7:0] page;
    begin
        page_hit = (page == PAGE_ID) || (page == `OFR_PAGE_ALL);
    end
endfunction

// next value of a 10us divider, restarting when cleared
function [7:0] div_next;
    input [7:0] cnt;
    input       clr;
    begin
        if (clr || (cnt == UNIT_LAST))
            div_next = 8'h00;
        else
            div_next = cnt + 8'h01;
    end
endfunction

// ****************************************************
// pin synchronisers
// ****************************************************
reg  [2:0]    run_sync_r;
reg  [2:0]    uv_sync_r;
reg           run_filt_r;
reg           uv_above_r;

// three stages; a change counts once stages two and three agree
always @(posedge mclk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        run_sync_r <= 3'h0;
        uv_sync_r  <= 3'h0;
        run_filt_r <= 1'b0;
        uv_above_r <= 1'b0;
    end
    else
    begin
        run_sync_r <= {run_sync_r[1:0], channel_run_pin_i};
        uv_sync_r  <= {uv_sync_r[1:0], uv_above_i};
        if (run_sync_r[1] == run_sync_r[2])
            run_filt_r <= run_sync_r[2];
        if (uv_sync_r[1] == uv_sync_r[2])
            uv_above_r <= uv_sync_r[2];
    end
end

// ****************************************************
// command registers
// ****************************************************
reg  [7:0]    oc_action_r;
reg  [7:0]    uv_action_r;
wire          wr_hit = cmd_wr_i && page_hit(cmd_page_i);
wire          uv_wr  = wr_hit && (cmd_code_i == `OFR_CMD_UV_RESP);
wire          uv_bad = cmd_data_i[`OFR_RESP_MSB:`OFR_RESP_LSB] == `OFR_RESP_BAD;
wire          cml_set = uv_wr && uv_bad;

// writes; a bad undervoltage response code is dropped, not stored
always @(posedge mclk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        oc_action_r <= `OFR_OC_RESP_RST;
        uv_action_r <= `OFR_UV_RESP_RST;
    end
    else
    begin
        if (wr_hit && (cmd_code_i == `OFR_CMD_OC_RESP))
            oc_action_r <= cmd_data_i;
        if (uv_wr && !uv_bad)
            uv_action_r <= cmd_data_i;
    end
end

// reads; unknown codes and other pages return zero
always @(posedge mclk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
        cmd_rd_data_o <= 8'h00;
    else if (cmd_rd_i)
    begin
        if (page_hit(cmd_page_i) && (cmd_code_i == `OFR_CMD_OC_RESP))
            cmd_rd_data_o <= oc_action_r;
        else if (page_hit(cmd_page_i) && (cmd_code_i == `OFR_CMD_UV_RESP))
            cmd_rd_data_o <= uv_action_r;
        else
            cmd_rd_data_o <= 8'h00;
    end
end

wire [1:0]    resp_code  = uv_action_r[`OFR_RESP_MSB:`OFR_RESP_LSB];
wire [2:0]    retry_code = uv_action_r[`OFR_RETRY_MSB:`OFR_RETRY_LSB];
wire [2:0]    dly_units  = uv_action_r[`OFR_DELAY_MSB:`OFR_DELAY_LSB];

// ****************************************************
// channel on/off and turn-on timing
// ****************************************************
reg  [2:0]    state_r;
reg  [2:0]    state_nxt;
reg           cmd_on_d_r;
reg  [7:0]    ton_div_r;
reg  [TW-1:0] ton_cnt_r;
reg           ton_done_r;
reg           thr_seen_r;
wire          cmd_on   = run_filt_r && operation_on_i;
wire          on_rise  = cmd_on && !cmd_on_d_r;
wire          driving  = (state_r == ST_RUN) || (state_r == ST_DELAY);
wire          ton_tick = driving && (ton_div_r == UNIT_LAST);
wire [TW-1:0] ton_limit_next = ton_cnt_r + {{(TW-1){1'b0}}, 1'b1};
wire          ton_hit  = ton_tick && !ton_done_r && (ton_limit_next == ton_max_limit_i);
wire          ton_fault = ton_hit && !thr_seen_r && (ton_max_limit_i != {TW{1'b0}});

// timeout window runs from each enable; zero limit means no window
always @(posedge mclk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        cmd_on_d_r <= 1'b0;
        ton_div_r  <= 8'h00;
        ton_cnt_r  <= {TW{1'b0}};
        ton_done_r <= 1'b0;
        thr_seen_r <= 1'b0;
    end
    else
    begin
        cmd_on_d_r <= cmd_on;
        ton_div_r  <= div_next(ton_div_r, !driving);
        if (!driving)
        begin
            ton_cnt_r  <= {TW{1'b0}};
            ton_done_r <= 1'b0;
            thr_seen_r <= 1'b0;
        end
        else
        begin
            if ((ton_max_limit_i == {TW{1'b0}}) || ton_hit)
                ton_done_r <= 1'b1;
            if (ton_tick && !ton_done_r)
                ton_cnt_r <= ton_limit_next;
            if (uv_above_r)
                thr_seen_r <= 1'b1;
        end
    end
end

// ****************************************************
// undervoltage detection with masking
// ****************************************************
// every start-up criterion must hold before a low output counts
wire          uv_armed = driving && cmd_on
                      && ton_done_r && ton_delay_done_i
                      && ton_rise_done_i && thr_seen_r
                      && !oc_present_i;
wire          uv_det   = uv_armed && !rise_active_i
                      && !fall_active_i && !uv_above_r;

// ****************************************************
// fault response sequencing
// ****************************************************
reg  [7:0]    st_div_r;
reg  [TW-1:0] st_cnt_r;
wire          st_tick = (st_div_r == UNIT_LAST);
wire          dly_over = ({{(TW-3){1'b0}}, dly_units} == st_cnt_r);
wire          rty_over = (restart_interval_setting_i <= st_cnt_r + {{(TW-1){1'b0}}, 1'b1});
wire          stop_rty = (retry_code != `OFR_RETRY_FOREVER) || other_latch_fault_i;

// response to an armed fault, from the running or delay state
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
            if (cmd_on)
                state_nxt = ST_RUN;
        ST_RUN:
            if (uv_det && (resp_code == `OFR_RESP_DELAYED))
                state_nxt = ST_DELAY;
            else if (uv_det && (resp_code == `OFR_RESP_SHUTDOWN))
                state_nxt = stop_rty ? ST_LATCH : ST_RETRY;
        ST_DELAY:
            if (!uv_det)
                state_nxt = ST_RUN;
            else if (dly_over)
                state_nxt = stop_rty ? ST_LATCH : ST_RETRY;
        ST_LATCH:
            if (clear_faults_i)
                state_nxt = ST_RUN;
        ST_RETRY:
            if (other_latch_fault_i)
                state_nxt = ST_LATCH;
            else if (st_tick && rty_over)
                state_nxt = ST_RUN;
        default:
            state_nxt = ST_IDLE;
    endcase
    // a command to turn off overrides every response
    if (!cmd_on)
        state_nxt = ST_IDLE;
end

// delay and retry counts restart on every state change
always @(posedge mclk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        state_r  <= ST_IDLE;
        st_div_r <= 8'h00;
        st_cnt_r <= {TW{1'b0}};
    end
    else
    begin
        state_r  <= state_nxt;
        st_div_r <= div_next(st_div_r, state_nxt != state_r);
        if (state_nxt != state_r)
            st_cnt_r <= {TW{1'b0}};
        else if (st_tick && (st_cnt_r != {TW{1'b1}}))
            st_cnt_r <= st_cnt_r + {{(TW-1){1'b0}}, 1'b1};
    end
end

// response 00 never leaves the running state, so drive is kept
assign chan_enable_o = driving;

// ****************************************************
// sticky status flags
// ****************************************************
// clear by command or a fresh turn-on; a new event wins over the clear
wire          flag_clr = clear_faults_i || on_rise;

always @(posedge mclk_i or posedge sys_rst_i)
begin
    if (sys_rst_i)
    begin
        status_word_vout_o <= 1'b0;
        status_vout_uv_o   <= 1'b0;
        status_vout_ton_o  <= 1'b0;
        status_byte_nota_o <= 1'b0;
        status_cml_o       <= 1'b0;
    end
    else
    begin
        if (uv_det || ton_fault)
            status_word_vout_o <= 1'b1;
        else if (flag_clr)
            status_word_vout_o <= 1'b0;
        if (uv_det)
            status_vout_uv_o <= 1'b1;
        else if (flag_clr)
            status_vout_uv_o <= 1'b0;
        if (ton_fault)
            status_vout_ton_o <= 1'b1;
        else if (flag_clr)
            status_vout_ton_o <= 1'b0;
        if (ton_fault)
            status_byte_nota_o <= 1'b1;
        else if (flag_clr)
            status_byte_nota_o <= 1'b0;
        if (cml_set)
            status_cml_o <= 1'b1;
        else if (flag_clr)
            status_cml_o <= 1'b0;
    end
end

// ****************************************************
// alert pin
// ****************************************************
// open drain: only ever pulled low, the pad input is not needed here
assign alert_out_o = 1'b0;
assign alert_oe_o  = (status_vout_uv_o && !uv_alert_mask_i)
                  || (status_vout_ton_o && !ton_alert_mask_i)
                  || status_cml_o;

endmodule // ofr_top

// ==== hw/ofr_regs.vh ====
// Behaviour
// - undervoltage fault sets summary, flag, alert
// - undervoltage detection waits for start-up criteria
// - undervoltage detection off while channel inactive
// - undervoltage detection off during rise, fall
// - response 00 keeps running, ignores fault
// - response 01 delays, then applies retry
// - response 10 disables output, then retry
// - response 11 rejected, raises logic fault
// - retry 000-110 latches output off
// - retry 111 restarts forever at interval
// - bits 2:0 count 10us delay units
// - flags hold until clear, cycle, power
// - turn-on timeout sets three flags, alert
// - turn-on timeout limit zero disables it
// - overcurrent response byte at 0x47, default 0
`ifndef OFR_REGS_VH
`define OFR_REGS_VH

// ****************************************************
// command codes and reset values
// ****************************************************
`define OFR_CMD_OC_RESP     8'h47
`define OFR_CMD_UV_RESP     8'hc5
`define OFR_OC_RESP_RST     8'h00
`define OFR_UV_RESP_RST     8'h00
`define OFR_PAGE_ALL        8'hff

// ****************************************************
// response byte fields
// ****************************************************
`define OFR_RESP_MSB        7
`define OFR_RESP_LSB        6
`define OFR_RETRY_MSB       5
`define OFR_RETRY_LSB       3
`define OFR_DELAY_MSB       2
`define OFR_DELAY_LSB       0
`define OFR_RESP_IGNORE     2'h0
`define OFR_RESP_DELAYED    2'h1
`define OFR_RESP_SHUTDOWN   2'h2
`define OFR_RESP_BAD        2'h3
`define OFR_RETRY_FOREVER   3'h7

// ****************************************************
// timing
// ****************************************************
`define OFR_CLK_PERIOD_NS   50
`define OFR_DELAY_UNIT_NS   10000
`define OFR_UNIT_CYCLES     ((`OFR_DELAY_UNIT_NS + `OFR_CLK_PERIOD_NS - 1) / `OFR_CLK_PERIOD_NS)

`endif

// ==== testbench/ofr_chk.sv ====
`timescale 1ns/100ps
`include "ofr_regs.vh"
module ofr_chk
#(
    parameter TW = 16
)
(
    // clock and reset
    input wire          mclk_i,
    input wire          sys_rst_i,
    // command port
    input wire          cmd_wr_i,
    input wire [7:0]    cmd_code_i,
    input wire [7:0]    cmd_page_i,
    input wire [7:0]    cmd_data_i,
    input wire          clear_faults_i,
    // settings and sequencer
    input wire [TW-1:0] ton_max_limit_i,
    input wire          uv_alert_mask_i,
    input wire          operation_on_i,
    input wire          ton_delay_done_i,
    input wire          ton_rise_done_i,
    input wire          rise_active_i,
    input wire          fall_active_i,
    input wire          oc_present_i,
    // flags and outputs
    input wire          status_word_vout_o,
    input wire          status_vout_uv_o,
    input wire          status_vout_ton_o,
    input wire          status_byte_nota_o,
    input wire          status_cml_o,
    input wire          chan_enable_o,
    input wire          alert_oe_o
);
    // ********
    // single domain, so one clocking for all
    // ********
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    uv_word_a: assert property ($rose(status_vout_uv_o) |-> status_word_vout_o)
        else $error("uv flag without word summary");
    uv_alert_a: assert property (status_vout_uv_o && !uv_alert_mask_i |-> alert_oe_o)
        else $error("unmasked uv flag without alert");
    alert_cause_a: assert property
        (!status_vout_uv_o && !status_vout_ton_o && !status_cml_o |-> !alert_oe_o)
        else $error("alert with no flag set");
    uv_gate_a: assert property ($rose(status_vout_uv_o) |-> $past(ton_delay_done_i
        && ton_rise_done_i && !oc_present_i && !rise_active_i && !fall_active_i))
        else $error("uv flag while detection gated");
    uv_idle_a: assert property ($rose(status_vout_uv_o) |-> $past(chan_enable_o))
        else $error("uv flag on inactive channel");
    uv_sticky_a: assert property (status_vout_uv_o && !clear_faults_i && operation_on_i
        && $past(operation_on_i) |=> status_vout_uv_o)
        else $error("uv flag dropped without clear");
    ton_flags_a: assert property
        ($rose(status_vout_ton_o) |-> status_byte_nota_o && status_word_vout_o)
        else $error("timeout flag without companions");
    ton_zero_a: assert property (ton_max_limit_i == 0 |-> !$rose(status_vout_ton_o))
        else $error("timeout fault with zero limit");
    cml_bad_a: assert property (cmd_wr_i && cmd_code_i == `OFR_CMD_UV_RESP
        && cmd_page_i == 8'h00 && cmd_data_i[7:6] == 2'h3 |=> status_cml_o)
        else $error("bad response code without logic fault");
endmodule // ofr_chk

bind ofr_top ofr_chk #(.TW(TW)) u_ofr_chk (
    .mclk_i             (mclk_i),
    .sys_rst_i          (sys_rst_i),
    .cmd_wr_i           (cmd_wr_i),
    .cmd_code_i         (cmd_code_i),
    .cmd_page_i         (cmd_page_i),
    .cmd_data_i         (cmd_data_i),
    .clear_faults_i     (clear_faults_i),
    .ton_max_limit_i    (ton_max_limit_i),
    .uv_alert_mask_i    (uv_alert_mask_i),
    .operation_on_i     (operation_on_i),
    .ton_delay_done_i   (ton_delay_done_i),
    .ton_rise_done_i    (ton_rise_done_i),
    .rise_active_i      (rise_active_i),
    .fall_active_i      (fall_active_i),
    .oc_present_i       (oc_present_i),
    .status_word_vout_o (status_word_vout_o),
    .status_vout_uv_o   (status_vout_uv_o),
    .status_vout_ton_o  (status_vout_ton_o),
    .status_byte_nota_o (status_byte_nota_o),
    .status_cml_o       (status_cml_o),
    .chan_enable_o      (chan_enable_o),
    .alert_oe_o         (alert_oe_o)
);

// ==== testbench/ofr_host_model.sv ====
`timescale 1ns/100ps
module ofr_host_model
(
    // clock
    input  wire       mclk_i,
    // command strobes towards the device
    output reg        cmd_wr_o,
    output reg        cmd_rd_o,
    output reg  [7:0] cmd_code_o,
    output reg  [7:0] cmd_page_o,
    output reg  [7:0] cmd_data_o,
    // read answer
    input  wire [7:0] cmd_rd_data_i
);
    // idle bus, strobes low
    initial
    begin
        {cmd_wr_o, cmd_rd_o, cmd_code_o, cmd_page_o, cmd_data_o} = 26'h0;
    end
    // one byte write; lines scrambled after, so stale data never matches
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        {cmd_code_o, cmd_page_o, cmd_data_o, cmd_wr_o} = {c, 8'h00, d, 1'b1};
        @(posedge mclk_i);
        #5;
        {cmd_code_o, cmd_page_o, cmd_data_o, cmd_wr_o} = {~c, 8'h5a, ~d, 1'b0};
        @(posedge mclk_i);
        #5;
    endtask
    // one byte read, answer taken once the strobe edge has landed
    task automatic rd(input logic [7:0] c, input logic [7:0] p, output logic [7:0] d);
        {cmd_code_o, cmd_page_o, cmd_rd_o} = {c, p, 1'b1};
        @(posedge mclk_i);
        #5;
        d = cmd_rd_data_i;
        {cmd_code_o, cmd_page_o, cmd_rd_o} = {~c, ~p, 1'b0};
        @(posedge mclk_i);
        #5;
    endtask
endmodule // ofr_host_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`include "ofr_regs.vh"
module tb;
    // ********
    // stimulus, design and host
    // ********
    logic        mclk_i = 0, sys_rst_i = 1, clr = 0, op = 0, run = 1, dd = 1, rdn = 1;
    logic        ra = 0, fa = 0, oc = 0, olf = 0, uva = 0, um = 0, tm = 0;
    logic [15:0] ri = 16'h0001, tl = 16'h0002;
    logic [7:0]  v;
    wire         wr, rd, aoe, en, fw, fuv, fton, fnota, fcml, alert_n;
    wire  [7:0]  code, page, wdat, rdat;
    int          err_count = 0, checks = 0, n;
    localparam   UV = `OFR_CMD_UV_RESP;
    assign alert_n = aoe ? 1'b0 : 1'b1; // pull-up unless sunk
    always #25 mclk_i = ~mclk_i;
    ofr_host_model u_ofr_host_model (.mclk_i(mclk_i), .cmd_wr_o(wr), .cmd_rd_o(rd),
        .cmd_code_o(code), .cmd_page_o(page), .cmd_data_o(wdat), .cmd_rd_data_i(rdat));
    ofr_top #(.PAGE_ID(8'h00), .TW(16)) u_ofr_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code), .cmd_page_i(page),
        .cmd_data_i(wdat), .clear_faults_i(clr), .cmd_rd_data_o(rdat),
        .restart_interval_setting_i(ri), .ton_max_limit_i(tl), .uv_alert_mask_i(um),
        .ton_alert_mask_i(tm), .channel_run_pin_i(run), .operation_on_i(op),
        .ton_delay_done_i(dd), .ton_rise_done_i(rdn), .rise_active_i(ra),
        .fall_active_i(fa), .oc_present_i(oc), .other_latch_fault_i(olf),
        .uv_above_i(uva), .status_word_vout_o(fw), .status_vout_uv_o(fuv),
        .status_vout_ton_o(fton), .status_byte_nota_o(fnota), .status_cml_o(fcml),
        .chan_enable_o(en), .alert_in_i(alert_n), .alert_out_o(), .alert_oe_o(aoe));
    // ********
    // shared tasks
    // ********
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #5;
    endtask
    task automatic rdc(input string nm, input logic [7:0] c, p, e);
        u_ofr_host_model.rd(c, p, v);
        chk(nm, e, v);
    endtask
    // bounded wait on enable, timeout flag or uv flag
    task automatic wt(input int s, input logic lv, input int lim, output int c);
        c = 0;
        while ((s == 0 ? en : s == 1 ? fton : fuv) !== lv && c < lim)
        begin
            cyc(1);
            c++;
        end
    endtask
    task automatic clrp;
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(1);
    endtask
    task automatic summarize;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ********
    // tests
    // ********
    initial
    begin
        cyc(4);
        sys_rst_i = 0;
        rdc("oc reset", 8'h47, 8'h00, 8'h00);
        u_ofr_host_model.wr(8'h47, 8'h5a);
        rdc("oc rw", 8'h47, 8'hff, 8'h5a);
        rdc("page miss", 8'h47, 8'h01, 8'h00);
        u_ofr_host_model.wr(UV, 8'hc0);
        chk("cml", 1, fcml);
        rdc("uv kept", UV, 8'h00, 8'h00);
        chk("cml alert", 0, alert_n);
        clrp;
        chk("cml clear", 0, fcml);
        // output never rises: timeout window elapses
        op = 1;
        wt(0, 1, 20, n);
        wt(1, 1, 600, n);
        chk("ton time", 1, n >= 398 && n <= 405);
        chk("ton nota", 1, fnota);
        chk("ton word", 1, fw);
        chk("ton alert", 0, alert_n);
        tm = 1;
        cyc(1);
        chk("ton mask", 1, alert_n);
        tm = 0;
        op = 0;
        clrp;
        tl = 16'h0000; // zero limit, discouraged but legal
        op = 1;
        wt(1, 1, 1000, n);
        chk("ton off", 0, fton);
        op = 0;
        cyc(5);
        tl = 16'h0001;
        uva = 1;
        // shutdown, latch off
        u_ofr_host_model.wr(UV, 8'h80);
        op = 1;
        cyc(260);
        {ra, uva} = 2'b10;
        cyc(20);
        chk("rise gate", 0, fuv);
        {ra, fa} = 2'b01;
        cyc(20);
        chk("fall gate", 0, fuv);
        {fa, oc} = 2'b01;
        cyc(20);
        chk("oc gate", 0, fuv);
        oc = 0;
        wt(2, 1, 10, n);
        chk("uv flag", 1, fw & fuv);
        chk("uv off", 0, en);
        uva = 1;
        cyc(500);
        chk("latched", 0, en);
        chk("sticky", 1, fuv);
        clrp;
        chk("cleared", 0, fuv);
        chk("restart", 1, en);
        // ignore, with alert masked
        u_ofr_host_model.wr(UV, 8'h00);
        um = 1;
        cyc(260);
        uva = 0;
        wt(2, 1, 10, n);
        cyc(50);
        chk("ignore runs", 3'h7, {fuv, en, alert_n});
        {um, uva} = 2'b01;
        cyc(6); // let the synced level settle, else the fault wins the clear
        clrp;
        chk("mask clear", 0, fuv);
        // delayed shutdown, two units, timer restarts on recovery
        u_ofr_host_model.wr(UV, 8'h42);
        uva = 0;
        cyc(300);
        chk("delay runs", 1, en);
        uva = 1;
        cyc(10);
        uva = 0;
        wt(0, 0, 600, n);
        chk("delay time", 1, n >= 400 && n <= 412);
        clrp;
        uva = 1;
        // endless retry at one unit
        u_ofr_host_model.wr(UV, 8'hb8);
        cyc(260);
        uva = 0;
        wt(0, 0, 10, n);
        uva = 1;
        wt(0, 1, 300, n);
        chk("retry time", 1, n >= 195 && n <= 205);
        op = 0;
        cyc(5);
        chk("off", 0, en);
        // a non-retry fault stops the endless retry
        olf = 1;
        op = 1;
        cyc(260);
        uva = 0;
        wt(0, 0, 20, n);
        cyc(300);
        chk("retry stop", 0, en);
        summarize;
    end
    // hang guard
    initial
    begin
        #2000000;
        err_count++;
        summarize;
    end
endmodule // tb
